// ===== hdl/port_e_pin_function_select.sv
// port e pin function selector with avalon register slave
`default_nettype none
// Contract
// - pin14 field: gpio, reserved, dma ack, hold
// - single-chip: pin14 dma/hold falls back gpio
// - upper bits 11..0 read zero
// - bit14 routes pin7 to timer ch2 b
// - bit12 routes pin6 to timer ch2 a
// - bit10 routes pin5 to timer ch1 b
// - bit8 routes pin4 to timer ch1 a
// - pin3 field: gpio, ch0 d, accepted 1
// - pin2 field: gpio, ch0 c, request 1
// - pin1 field: gpio, ch0 b, accepted 0
// - pin0 field: gpio, ch0 a, request 0
// - single-chip: pins 3..0 dma fall back gpio
// - all mode fields zero after reset
// - only power-on reset clears select registers
// - direction bit sets gpio/timer pin direction
module port_e_pin_function_select
  import pin_select_pkg::*;
#(
  parameter int NUM_PINS = 16
) (
  // clock and power-on reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // avalon-mm slave
  input  wire logic [3:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  // operating mode strap level
  input  wire logic                single_chip_mode,
  // package pins
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_out,
  output logic      [NUM_PINS-1:0] pin_oe_n,
  // general i/o port data
  input  wire logic [NUM_PINS-1:0] gpio_out,
  output logic      [NUM_PINS-1:0] gpio_in,
  // timer capture/compare lines, ch0 a..d, ch1 a,b, ch2 a,b
  input  wire logic [7:0]          timer_out,
  output logic      [7:0]          timer_in,
  // dma controller
  output logic                     dma_request_0,
  output logic                     dma_request_1,
  input  wire logic                dma_req_accepted_0,
  input  wire logic                dma_req_accepted_1,
  input  wire logic                dma_ack_0,
  // bus controller
  input  wire logic                address_hold_strobe
);

  logic [15:0]         upper_r;
  logic [15:0]         lower_r;
  logic [15:0]         dir_r;
  logic                ack_r;
  logic [NUM_PINS-1:0] pin_s;
  logic                sc_s;
  func_t               fn [NUM_PINS];
  logic [NUM_PINS-1:0] sp;
  logic [NUM_PINS-1:0] tmr_o;
  logic [NUM_PINS-1:0] route_out;
  logic [NUM_PINS-1:0] route_oe_n;
  logic [NUM_PINS-1:0] status_nxt;
  logic [7:0]          timer_in_nxt;
  logic [15:0]         rd_nxt;
  logic                wr_take;
  logic                rd_take;

  // merge the enabled byte lanes, then clear reserved bits
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  be,
                                          input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      v[15:8] = wdata[15:8];
    end
    return v & mask;
  endfunction

  // two-bit field of pins 3..0; dma choice yields to single-chip mode
  function automatic func_t decode_pair(input logic [1:0] sel,
                                        input func_t      alt,
                                        input logic       single);
    func_t r;
    r = FN_GPIO;
    case (sel)
      SEL_TIMER: r = FN_TIMER;
      SEL_DMA:   r = single ? FN_GPIO : alt;
      default:   r = FN_GPIO;
    endcase
    return r;
  endfunction

  // pin levels and mode strap come from outside the clock domain
  bit_sync #(
    .WIDTH (NUM_PINS + 1)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({single_chip_mode, pin_in}),
    .sync_out ({sc_s, pin_s})
  );

  // one wait cycle per access; waitrequest drops in the second cycle
  assign waitrequest = (read | write) & ~ack_r;
  assign wr_take     = write & ack_r;
  assign rd_take     = read & ~ack_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  // select registers; rst_n is the power-on reset only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      upper_r <= UPPER_RESET;
      lower_r <= LOWER_RESET;
    end else if (wr_take) begin
      if (address[3:2] == OFF_UPPER_SELECT[3:2]) begin
        upper_r <= merge16(upper_r, writedata, byteenable, UPPER_WMASK);
      end
      if (address[3:2] == OFF_LOWER_SELECT[3:2]) begin
        lower_r <= merge16(lower_r, writedata, byteenable, LOWER_WMASK);
      end
    end
  end

  // direction register for gpio and timer pins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dir_r <= DIRECTION_RESET;
    end else if (wr_take && address[3:2] == OFF_DIRECTION[3:2]) begin
      dir_r <= merge16(dir_r, writedata, byteenable, DIRECTION_WMASK);
    end
  end

  // read mux; unmapped words cannot occur, status is read-only
  always_comb begin
    rd_nxt = 16'h0000;
    case (address[3:2])
      OFF_UPPER_SELECT[3:2]: rd_nxt = upper_r & UPPER_WMASK;
      OFF_LOWER_SELECT[3:2]: rd_nxt = lower_r & LOWER_WMASK;
      OFF_DIRECTION[3:2]:    rd_nxt = dir_r;
      default:               rd_nxt = status_nxt;
    endcase
  end

  // read data captured in the wait cycle, held until the next read
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      readdata <= {16'h0000, rd_nxt};
    end
  end

  // resolve each pin's function from the fields and the mode
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      fn[i] = FN_GPIO;
    end
    // odd pins drive accepted strobes, even pins sense requests
    for (int i = 0; i < 4; i++) begin
      fn[i] = decode_pair(lower_r[PAIR_SEL_LSB + FIELD_STEP*i +: 2],
                          (i % 2 == 1) ? FN_DRIVE : FN_SENSE,
                          sc_s);
    end
    for (int i = 4; i < 8; i++) begin
      fn[i] = lower_r[TIMER_SEL_LSB + FIELD_STEP*(i-4)] ? FN_TIMER
                                                        : FN_GPIO;
    end
    case (upper_r[PIN14_SEL_LSB +: 2])
      SEL_DMA:  fn[PIN14_INDEX] = sc_s ? FN_GPIO : FN_DRIVE;
      SEL_HOLD: fn[PIN14_INDEX] = sc_s ? FN_GPIO : FN_DRIVE;
      default:  fn[PIN14_INDEX] = FN_GPIO;
    endcase
  end

  // driven strobes per pin; unused entries stay low
  always_comb begin
    sp                = '0;
    sp[1]             = dma_req_accepted_0;
    sp[3]             = dma_req_accepted_1;
    sp[PIN14_INDEX]   = upper_r[PIN14_SEL_LSB] ? address_hold_strobe
                                               : dma_ack_0;
  end

  assign tmr_o = {{(NUM_PINS-8){1'b0}}, timer_out};

  // one routing cell per pin
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    pin_route u_route (
      .func        (fn[g]),
      .dir         (dir_r[g]),
      .gpio_out    (gpio_out[g]),
      .timer_out   (tmr_o[g]),
      .special_out (sp[g]),
      .out_v       (route_out[g]),
      .oe_n_v      (route_oe_n[g])
    );
  end

  // inbound levels reach the timer only on timer-selected pins; gpio_in always gets them
  always_comb begin
    timer_in_nxt = 8'h00;
    for (int i = 0; i < 8; i++) begin
      timer_in_nxt[i] = (fn[i] == FN_TIMER) & pin_s[i];
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      status_nxt[i] = (fn[i] != FN_GPIO);
    end
  end

  // registered pin drive; pins float as inputs out of reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= route_out;
      pin_oe_n <= route_oe_n;
    end
  end

  // registered levels toward the port, timer and dma
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gpio_in       <= '0;
      timer_in      <= 8'h00;
      dma_request_0 <= 1'b0;
      dma_request_1 <= 1'b0;
    end else begin
      gpio_in       <= pin_s;
      timer_in      <= timer_in_nxt;
      dma_request_0 <= (fn[0] == FN_SENSE) & pin_s[0];
      dma_request_1 <= (fn[2] == FN_SENSE) & pin_s[2];
    end
  end

  // upper register reads keep reserved bits clear
  property p_upper_reserved;
    @(posedge mclk) disable iff (!rst_n)
      (read && !waitrequest && address[3:2] == OFF_UPPER_SELECT[3:2])
        |-> readdata[11:0] == 12'h000;
  endproperty
  a_upper_reserved: assert property (p_upper_reserved)
    else $error("upper select reserved bits read nonzero");

  // lower register write lands masked one edge later
  property p_lower_write;
    @(posedge mclk) disable iff (!rst_n)
      (write && !waitrequest && address[3:2] == OFF_LOWER_SELECT[3:2]
       && byteenable[1:0] == 2'h3)
        |=> lower_r == ($past(writedata[15:0]) & 16'h55FF);
  endproperty
  a_lower_write: assert property (p_lower_write)
    else $error("lower select write not stored with reserved bits clear");

  // pin14 hold selection drives the bus strobe
  property p_pin14_hold;
    @(posedge mclk) disable iff (!rst_n)
      (upper_r[13:12] == 2'h3 && !sc_s)
        |=> (pin_out[14] == $past(address_hold_strobe)) && !pin_oe_n[14];
  endproperty
  a_pin14_hold: assert property (p_pin14_hold)
    else $error("pin14 hold selection not driving strobe");

  // pin14 falls back to gpio in single-chip mode
  property p_pin14_single;
    @(posedge mclk) disable iff (!rst_n)
      (upper_r[13] && sc_s)
        |=> (pin_oe_n[14] == !$past(dir_r[14]))
            && (pin_out[14] == $past(gpio_out[14]));
  endproperty
  a_pin14_single: assert property (p_pin14_single)
    else $error("pin14 not gpio in single-chip mode");

  // timer selection on pin7 follows the timer and direction
  property p_pin7_timer;
    @(posedge mclk) disable iff (!rst_n)
      lower_r[14]
        |=> (pin_out[7] == $past(timer_out[7]))
            && (pin_oe_n[7] == !$past(dir_r[7]));
  endproperty
  a_pin7_timer: assert property (p_pin7_timer)
    else $error("pin7 timer route wrong");

  // pin4 in gpio keeps its level from the timer and drives the port value
  property p_pin4_gpio;
    @(posedge mclk) disable iff (!rst_n)
      !lower_r[8] ##1 !lower_r[8] |-> !timer_in[4] && pin_out[4] == $past(gpio_out[4]);
  endproperty
  a_pin4_gpio: assert property (p_pin4_gpio)
    else $error("pin4 gpio route wrong");

  // pin3 accepted strobe outside single-chip mode
  property p_pin3_dma;
    @(posedge mclk) disable iff (!rst_n)
      (lower_r[7:6] == 2'h2 && !sc_s)
        |=> (pin_out[3] == $past(dma_req_accepted_1)) && !pin_oe_n[3];
  endproperty
  a_pin3_dma: assert property (p_pin3_dma)
    else $error("pin3 accepted strobe not driven");

  // pin2 request sensed into the dma controller
  property p_pin2_request;
    @(posedge mclk) disable iff (!rst_n)
      (lower_r[5:4] == 2'h2 && !sc_s)
        |=> (dma_request_1 == $past(pin_s[2])) && pin_oe_n[2];
  endproperty
  a_pin2_request: assert property (p_pin2_request)
    else $error("pin2 request route wrong");

  // pin1 dma selection yields to gpio in single-chip mode
  property p_pin1_single;
    @(posedge mclk) disable iff (!rst_n)
      (lower_r[3:2] == 2'h2 && sc_s)
        |=> pin_oe_n[1] == !$past(dir_r[1]);
  endproperty
  a_pin1_single: assert property (p_pin1_single)
    else $error("pin1 not gpio in single-chip mode");

  // reserved pin3 encoding acts as gpio
  property p_pin3_reserved;
    @(posedge mclk) disable iff (!rst_n)
      (lower_r[7:6] == 2'h3)
        |=> (pin_out[3] == $past(gpio_out[3]))
            && (pin_oe_n[3] == !$past(dir_r[3]));
  endproperty
  a_pin3_reserved: assert property (p_pin3_reserved)
    else $error("pin3 reserved encoding not gpio");

  // reset clears every mode field
  property p_reset_clear;
    @(posedge mclk)
      !rst_n |=> (upper_r == 16'h0000) && (lower_r == 16'h0000) && pin_oe_n[14];
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("select registers not clear after reset");

endmodule
`default_nettype wire

// ===== shared/pin_select_pkg.sv
// shared constants and types for the port e pin function selector
`default_nettype none
package pin_select_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0]  OFF_UPPER_SELECT = 4'h0;
  localparam logic [3:0]  OFF_LOWER_SELECT = 4'h4;
  localparam logic [3:0]  OFF_DIRECTION    = 4'h8;
  localparam logic [3:0]  OFF_ROUTE_STATUS = 4'hC;
  // values after power-on reset
  localparam logic [15:0] UPPER_RESET      = 16'h0000;
  localparam logic [15:0] LOWER_RESET      = 16'h0000;
  localparam logic [15:0] DIRECTION_RESET  = 16'h0000;
  // writable bits; everything else reads as zero
  localparam logic [15:0] UPPER_WMASK      = 16'h3000;
  localparam logic [15:0] LOWER_WMASK      = 16'h55FF;
  localparam logic [15:0] DIRECTION_WMASK  = 16'hFFFF;
  // field positions
  localparam int          PIN14_SEL_LSB    = 12;
  localparam int          PAIR_SEL_LSB     = 0;
  localparam int          TIMER_SEL_LSB    = 8;
  localparam int          FIELD_STEP       = 2;
  localparam int          PIN14_INDEX      = 14;
  // two-bit field encodings
  localparam logic [1:0]  SEL_GPIO         = 2'h0;
  localparam logic [1:0]  SEL_TIMER        = 2'h1;
  localparam logic [1:0]  SEL_DMA          = 2'h2;
  localparam logic [1:0]  SEL_HOLD         = 2'h3;
  // resolved pin function
  typedef enum logic [1:0] {
    FN_GPIO,
    FN_TIMER,
    FN_DRIVE,
    FN_SENSE
  } func_t;
endpackage
`default_nettype wire

// ===== hdl/bit_sync.sv
// two-flop synchroniser for asynchronous pin levels
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pin_route.sv
// per-pin output and enable selection from the resolved function
`default_nettype none
module pin_route
  import pin_select_pkg::*;
(
  // selection
  input  wire func_t func,
  input  wire logic  dir,
  // sources
  input  wire logic  gpio_out,
  input  wire logic  timer_out,
  input  wire logic  special_out,
  // pin drive
  output logic       out_v,
  output logic       oe_n_v
);
  // only the chosen source reaches the pin
  always_comb begin
    out_v  = gpio_out;
    oe_n_v = ~dir;
    case (func)
      FN_TIMER: begin
        out_v  = timer_out;
        oe_n_v = ~dir;
      end
      FN_DRIVE: begin
        out_v  = special_out;
        oe_n_v = 1'b0;
      end
      FN_SENSE: begin
        out_v  = 1'b0;
        oe_n_v = 1'b1;
      end
      default: begin
        out_v  = gpio_out;
        oe_n_v = ~dir;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== testbench/engine_model.sv
// behavioural timer, dma and bus controller behind the pin selector
`default_nettype none
module engine_model (
  // clock
  input  wire logic       mclk,
  // bench control: swap every line to its opposite level
  input  wire logic       flip,
  // timer capture/compare outputs
  output logic      [7:0] timer_out,
  // dma and bus strobes
  output logic            dma_req_accepted_0,
  output logic            dma_req_accepted_1,
  output logic            dma_ack_0,
  output logic            address_hold_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // registered like real on-chip logic, so nothing moves mid-cycle
  always_ff @(posedge mclk) begin
    timer_out           <= flip ? 8'h96 : 8'h69;
    dma_req_accepted_0  <= flip;
    dma_req_accepted_1  <= ~flip;
    dma_ack_0           <= flip;
    address_hold_strobe <= ~flip;
  end
endmodule
`default_nettype wire

// ===== testbench/test_port_e_pin_function_select.sv
// self-checking bench for the port e pin function selector
`default_nettype none
module test_port_e_pin_function_select
  import pin_select_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  // gpio pattern chosen to differ from every strobe level used
  localparam logic [15:0] G = 16'hA5C8;
  logic        mclk             = 1'b0;
  logic        rst_n            = 1'b0;
  logic [3:0]  address          = 4'h0;
  logic        read             = 1'b0;
  logic        write            = 1'b0;
  logic [31:0] writedata        = 32'h0;
  logic [3:0]  byteenable       = 4'hF;
  logic        single_chip_mode = 1'b0;
  logic [15:0] pin_in           = 16'h0;
  logic [15:0] gpio_out         = G;
  logic        flip             = 1'b0;
  logic [31:0] readdata, rd;
  logic        waitrequest, dma_request_0, dma_request_1;
  logic [15:0] pin_out, pin_oe_n, gpio_in;
  logic [7:0]  timer_out, timer_in;
  logic        dma_req_accepted_0, dma_req_accepted_1, dma_ack_0, address_hold_strobe;
  int          err_count = 0;
  int          tests_run = 0;

  port_e_pin_function_select dut (
    .mclk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .single_chip_mode, .pin_in, .pin_out, .pin_oe_n, .gpio_out,
    .gpio_in, .timer_out, .timer_in, .dma_request_0, .dma_request_1,
    .dma_req_accepted_0, .dma_req_accepted_1, .dma_ack_0, .address_hold_strobe
  );
  engine_model engine (
    .mclk, .flip, .timer_out, .dma_req_accepted_0, .dma_req_accepted_1,
    .dma_ack_0, .address_hold_strobe
  );

  // 50 MHz clock
  always #10 mclk = ~mclk;

  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      err_count++;
      $display("BAD %0t bus never answered", $time);
      report_and_stop();
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, "readback");
  endtask

  // only pins the device drives have a defined output value
  task automatic pins(input logic [15:0] eo, input logic [15:0] en);
    repeat (3) @(posedge mclk);
    chk(pin_oe_n, en, "pin enable");
    chk(pin_out & ~en, eo & ~en, "pin value");
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("BAD %0t run did not finish", $time);
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    chk(pin_oe_n, 16'hFFFF, "reset enable");
    rchk(OFF_UPPER_SELECT, 32'h0);
    rchk(OFF_LOWER_SELECT, 32'h0);
    // software keeps reserved bits at zero on every write
    bus(1'b1, OFF_UPPER_SELECT, 32'h0000_3000);
    rchk(OFF_UPPER_SELECT, 32'h0000_3000);
    bus(1'b1, OFF_LOWER_SELECT, 32'h0000_55FF);
    rchk(OFF_LOWER_SELECT, 32'h0000_55FF);
    // pin14 drives the hold strobe, reserved pairs stay plain inputs
    pins({G[15], 1'b1, G[13:0]}, 16'hBFFF);
    // all eight timer lines, outputs, then the opposite levels
    bus(1'b1, OFF_UPPER_SELECT, 32'h0);
    bus(1'b1, OFF_DIRECTION, 32'h0000_FFFF);
    bus(1'b1, OFF_LOWER_SELECT, 32'h0000_5555);
    pins({G[15:8], 8'h69}, 16'h0000);
    flip <= 1'b1;
    pins({G[15:8], 8'h96}, 16'h0000);
    // dma functions on pins 3..0
    bus(1'b1, OFF_LOWER_SELECT, 32'h0000_00AA);
    pin_in <= 16'h0005;
    pins({G[15:4], 4'b0010}, 16'h0005);
    repeat (2) @(posedge mclk);
    chk(dma_request_0, 1'b1, "request 0");
    chk(dma_request_1, 1'b1, "request 1");
    rchk(OFF_ROUTE_STATUS, 32'h0000_000F);
    single_chip_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    pins(G, 16'h0000);
    chk(dma_request_0, 1'b0, "request 0 single");
    chk(dma_request_1, 1'b0, "request 1 single");
    // pin 14 functions
    single_chip_mode <= 1'b0;
    bus(1'b1, OFF_LOWER_SELECT, 32'h0);
    bus(1'b1, OFF_UPPER_SELECT, 32'h0000_2000);
    pins({G[15], 1'b1, G[13:0]}, 16'h0000);
    flip <= 1'b0;
    bus(1'b1, OFF_UPPER_SELECT, 32'h0000_3000);
    pins({G[15], 1'b1, G[13:0]}, 16'h0000);
    bus(1'b1, OFF_UPPER_SELECT, 32'h0000_1000);
    pins(G, 16'h0000);
    bus(1'b1, OFF_UPPER_SELECT, 32'h0000_3000);
    single_chip_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    pins(G, 16'h0000);
    single_chip_mode <= 1'b0;
    bus(1'b1, OFF_LOWER_SELECT, 32'h0000_00FF);
    // hold strobe is high while flip is low
    pins({G[15], 1'b1, G[13:0]}, 16'h0000);
    // inbound path with every pin but pin14 as an input
    bus(1'b1, OFF_DIRECTION, 32'h0);
    bus(1'b1, OFF_LOWER_SELECT, 32'h0000_5555);
    pin_in <= 16'h00C3;
    // pin14 still drives the hold strobe high
    pins(16'h4000, 16'hBFFF);
    // two sync flops plus the output flop: level shows after a fourth edge
    @(posedge mclk);
    chk(timer_in, 8'hC3, "timer in");
    chk(gpio_in, 16'h00C3, "gpio in");
    bus(1'b1, OFF_LOWER_SELECT, 32'h0);
    repeat (4) @(posedge mclk);
    chk(timer_in, 8'h00, "timer in idle");
    // status word is read-only
    bus(1'b1, OFF_ROUTE_STATUS, 32'h0000_FFFF);
    rchk(OFF_ROUTE_STATUS, 32'h0000_4000);
    // only the enabled low byte lane lands
    byteenable <= 4'h1;
    bus(1'b1, OFF_LOWER_SELECT, 32'h0000_55AA);
    byteenable <= 4'hF;
    rchk(OFF_LOWER_SELECT, 32'h0000_00AA);
    // mid-run power-on reset clears both selects
    bus(1'b1, OFF_LOWER_SELECT, 32'h0000_5555);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(OFF_UPPER_SELECT, 32'h0);
    rchk(OFF_LOWER_SELECT, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
